// ### design/cell_interrupt_enable_status.sv
/*
  Cell interface interrupt enables, transmit and receive indication
  registers, idle-cell header mask bytes for octets 2 to 4, and the
  host interrupt pin qualification, behind an AXI4-Lite slave.
  Assumes one clock, a synchronous active-low reset, and status levels
  and header words produced by logic on the same clock.
*/
// The AXI4-Lite interface to the registers was left to the implementer.
// Summary of operation
// - three RW mask bytes for idle header octets 2-4, reset zero
// - a set mask bit makes idle compare ignore that header bit
// - tx indication drives pin only with own, summary, port, pin enable
// - rx indication drives pin only with own, summary, port, pin enable
// - tx enable register bits 7..3 hold enables, reset to one
// - rx enable register bits 7..5 and 3..0 hold enables, reset one
// - tx indication bits 7..3 match enable bits; bits 1,0 read zero
// - tx indication sets only on enabled rising edge of status
// - reading tx indication returns latched bits then clears them
// - delineation loss sets on either edge, others rising; read clears
`timescale 1ns/10ps
`include "cell_irq_defs.svh"
module cell_interrupt_enable_status
  import cell_irq_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [11:0] awaddr,
  // axi4-lite write data
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  // axi4-lite write response
  output logic             bvalid,
  input  wire logic        bready,
  output logic      [1:0]  bresp,
  // axi4-lite read address
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [11:0] araddr,
  // axi4-lite read data
  output logic             rvalid,
  input  wire logic        rready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  // cell status levels
  input  wire tx_status_t  tx_status,
  input  wire logic [7:0]  rx_status,
  // idle cell screening
  input  wire logic        hdr_valid,
  input  wire cell_hdr_t   rx_hdr,
  input  wire cell_hdr_t   idle_hdr,
  input  wire logic [7:0]  idle_mask_byte1,
  output logic             idle_match,
  // interrupts
  output logic             host_irq_n,
  output logic             irq
);

  // ----------------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------------
  logic [7:0] idle_mask_byte2_q;
  logic [7:0] idle_mask_byte3_q;
  logic [7:0] idle_mask_byte4_q;
  logic [7:0] tx_en_q;
  logic [7:0] rx_en_q;
  logic [7:0] summary_en_q;
  logic [7:0] port_en_q;
  logic [7:0] mode_q;
  logic [1:0] evt_status_q;
  logic [1:0] evt_mask_q;

  // ----------------------------------------------------------------------
  // bus handshake state
  // ----------------------------------------------------------------------
  logic        aw_held_q;
  logic        w_held_q;
  logic [9:0]  aw_idx_q;
  logic [7:0]  w_byte_q;
  logic        w_lane0_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  // ----------------------------------------------------------------------
  // indication logic
  // ----------------------------------------------------------------------
  logic [7:0] tx_pend;
  logic [7:0] rx_pend;
  logic       tx_new;
  logic       rx_new;
  logic       tx_clr;
  logic       rx_clr;
  logic [7:0] tx_level;
  logic       do_write;
  logic       rd_take;
  logic [9:0] ar_idx;
  logic [7:0] rd_byte;
  logic       rd_hit;
  logic       pin_req;
  logic       idle_match_q;
  logic       host_irq_n_q;
  logic       irq_q;

  // ----------------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------------

  // each channel is taken on its own; both held completes the write
  assign awready  = !aw_held_q && !bvalid_q;
  assign wready   = !w_held_q && !bvalid_q;
  assign do_write = aw_held_q && w_held_q && !bvalid_q;

  // capture write address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      aw_idx_q  <= 10'h000;
    end
    else if (awvalid && awready)
    begin
      aw_held_q <= 1'b1;
      aw_idx_q  <= awaddr[11:2];
    end
    else if (do_write)
      aw_held_q <= 1'b0;
  end

  // capture write data; only byte lane 0 carries register bits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_q  <= 1'b0;
      w_byte_q  <= 8'h00;
      w_lane0_q <= 1'b0;
    end
    else if (wvalid && wready)
    begin
      w_held_q  <= 1'b1;
      w_byte_q  <= wdata[7:0];
      w_lane0_q <= wstrb[0];
    end
    else if (do_write)
      w_held_q <= 1'b0;
  end

  // write response; unmapped index answers slverr, no state changes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= `RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_q <= 1'b1;
      unique case (aw_idx_q)
        `IDX_SUMMARY_EN, `IDX_MASK2, `IDX_MASK3, `IDX_MASK4,
        `IDX_TX_EN, `IDX_RX_EN, `IDX_TX_PEND, `IDX_RX_PEND,
        `IDX_PORT_EN, `IDX_MODE, `IDX_EVT_STATUS, `IDX_EVT_MASK:
          bresp_q <= `RESP_OKAY;
        default:
          bresp_q <= `RESP_SLVERR;
      endcase
    end
    else if (bready)
      bvalid_q <= 1'b0;
  end

  assign bvalid = bvalid_q;
  assign bresp  = bresp_q;

  // ----------------------------------------------------------------------
  // read/write registers
  // ----------------------------------------------------------------------

  // idle mask bytes for header octets 2 to 4
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      idle_mask_byte2_q <= `RST_MASK;
      idle_mask_byte3_q <= `RST_MASK;
      idle_mask_byte4_q <= `RST_MASK;
    end
    else if (do_write && w_lane0_q)
    begin
      if (aw_idx_q == `IDX_MASK2)
        idle_mask_byte2_q <= w_byte_q;
      if (aw_idx_q == `IDX_MASK3)
        idle_mask_byte3_q <= w_byte_q;
      if (aw_idx_q == `IDX_MASK4)
        idle_mask_byte4_q <= w_byte_q;
    end
  end

  // cell interrupt enables; reserved bits stored as written so
  // software sees back what it put there
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_en_q <= `RST_TX_EN;
      rx_en_q <= `RST_RX_EN;
    end
    else if (do_write && w_lane0_q)
    begin
      if (aw_idx_q == `IDX_TX_EN)
        tx_en_q <= w_byte_q;
      if (aw_idx_q == `IDX_RX_EN)
        rx_en_q <= w_byte_q;
    end
  end

  // summary, port and pin enables of this port
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      summary_en_q <= `RST_CTRL;
      port_en_q    <= `RST_CTRL;
      mode_q       <= `RST_CTRL;
    end
    else if (do_write && w_lane0_q)
    begin
      if (aw_idx_q == `IDX_SUMMARY_EN)
        summary_en_q <= w_byte_q;
      if (aw_idx_q == `IDX_PORT_EN)
        port_en_q <= w_byte_q;
      if (aw_idx_q == `IDX_MODE)
        mode_q <= w_byte_q;
    end
  end

  // event mask for the level irq output
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      evt_mask_q <= 2'b00;
    else if (do_write && w_lane0_q && aw_idx_q == `IDX_EVT_MASK)
      evt_mask_q <= w_byte_q[1:0];
  end

  // sticky events, write one to clear; a new event in the clearing
  // cycle wins so it is never lost
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      evt_status_q <= 2'b00;
    else
    begin
      if (do_write && w_lane0_q && aw_idx_q == `IDX_EVT_STATUS)
        evt_status_q[`BIT_EVT_TX] <= tx_new ||
          (evt_status_q[`BIT_EVT_TX] && !w_byte_q[`BIT_EVT_TX]);
      else
        evt_status_q[`BIT_EVT_TX] <= tx_new || evt_status_q[`BIT_EVT_TX];
      if (do_write && w_lane0_q && aw_idx_q == `IDX_EVT_STATUS)
        evt_status_q[`BIT_EVT_RX] <= rx_new ||
          (evt_status_q[`BIT_EVT_RX] && !w_byte_q[`BIT_EVT_RX]);
      else
        evt_status_q[`BIT_EVT_RX] <= rx_new || evt_status_q[`BIT_EVT_RX];
    end
  end

  // ----------------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------------

  // one read outstanding; a new address only once the data has gone
  assign arready = !rvalid_q;
  assign rd_take = arvalid && arready;
  assign ar_idx  = araddr[11:2];

  // read data selection
  always_comb
  begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    unique case (ar_idx)
      `IDX_SUMMARY_EN: rd_byte = summary_en_q;
      `IDX_MASK2:      rd_byte = idle_mask_byte2_q;
      `IDX_MASK3:      rd_byte = idle_mask_byte3_q;
      `IDX_MASK4:      rd_byte = idle_mask_byte4_q;
      `IDX_TX_EN:      rd_byte = tx_en_q;
      `IDX_RX_EN:      rd_byte = rx_en_q;
      `IDX_TX_PEND:    rd_byte = tx_pend & `TX_PEND_BITS;
      `IDX_RX_PEND:    rd_byte = rx_pend & `RX_PEND_BITS;
      `IDX_PORT_EN:    rd_byte = port_en_q;
      `IDX_MODE:       rd_byte = mode_q;
      `IDX_EVT_STATUS: rd_byte = {6'h00, evt_status_q};
      `IDX_EVT_MASK:   rd_byte = {6'h00, evt_mask_q};
      default:         rd_hit  = 1'b0;
    endcase
  end

  // registered read answer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `RESP_OKAY;
    end
    else if (rd_take)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= {24'h00_0000, rd_byte};
      rresp_q  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (rready)
      rvalid_q <= 1'b0;
  end

  assign rvalid = rvalid_q;
  assign rdata  = rdata_q;
  assign rresp  = rresp_q;

  // reading an indication register clears what was returned
  assign tx_clr = rd_take && ar_idx == `IDX_TX_PEND;
  assign rx_clr = rd_take && ar_idx == `IDX_RX_PEND;

  // ----------------------------------------------------------------------
  // indication registers
  // ----------------------------------------------------------------------

  // transmit status lines up on bits 7..3; bits 2..0 can never set
  assign tx_level = {tx_status, 3'b000};

  edge_latch #(
    .WIDTH (8),
    .DUAL  (8'h00)
  ) u_tx_pend (
    .aclk    (aclk),
    .aresetn (aresetn),
    .status  (tx_level),
    .enable  (tx_en_q & `TX_PEND_BITS),
    .clear   (tx_clr),
    .pend    (tx_pend),
    .any_set (tx_new)
  );

  // receive side; delineation loss fires on both edges
  edge_latch #(
    .WIDTH (8),
    .DUAL  (`RX_DUAL_EDGE)
  ) u_rx_pend (
    .aclk    (aclk),
    .aresetn (aresetn),
    .status  (rx_status),
    .enable  (rx_en_q & `RX_PEND_BITS),
    .clear   (rx_clr),
    .pend    (rx_pend),
    .any_set (rx_new)
  );

  // ----------------------------------------------------------------------
  // interrupt pin qualification
  // ----------------------------------------------------------------------

  // an enable cleared after a bit latched still withholds it from the pin
  assign pin_req = mode_q[`BIT_PIN_EN] && port_en_q[`BIT_PORT_EN] &&
    ((summary_en_q[`BIT_TX_SUMMARY] && |(tx_pend & tx_en_q &
      `TX_PEND_BITS)) ||
     (summary_en_q[`BIT_RX_SUMMARY] && |(rx_pend & rx_en_q &
      `RX_PEND_BITS)));

  // pins from flip-flops, so no glitch reaches the host
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      host_irq_n_q <= 1'b1;
      irq_q        <= 1'b0;
    end
    else
    begin
      host_irq_n_q <= !pin_req;
      irq_q        <= |(evt_status_q & evt_mask_q);
    end
  end

  assign host_irq_n = host_irq_n_q;
  assign irq        = irq_q;

  // ----------------------------------------------------------------------
  // idle cell screening
  // ----------------------------------------------------------------------

  // masked bits drop out of the compare, so either value matches
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      idle_match_q <= 1'b0;
    else
      idle_match_q <= hdr_valid &&
        (((rx_hdr ^ idle_hdr) &
          ~{idle_mask_byte1, idle_mask_byte2_q,
            idle_mask_byte3_q, idle_mask_byte4_q}) == 32'h0000_0000);
  end

  assign idle_match = idle_match_q;

endmodule // cell_interrupt_enable_status

// ### design/cell_irq_defs.svh
/*
  Register indices, field positions, reset values and bus constants of
  the cell interrupt block. Assumes a 32-bit AXI4-Lite slave in which
  register index N sits at byte address 4*N.
*/
`ifndef CELL_IRQ_DEFS_SVH
`define CELL_IRQ_DEFS_SVH

// ----------------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------------
`define IDX_SUMMARY_EN   10'h001
`define IDX_MASK2        10'h025
`define IDX_MASK3        10'h026
`define IDX_MASK4        10'h027
`define IDX_TX_EN        10'h028
`define IDX_RX_EN        10'h029
`define IDX_TX_PEND      10'h02c
`define IDX_RX_PEND      10'h02d
`define IDX_PORT_EN      10'h201
`define IDX_MODE         10'h202
`define IDX_EVT_STATUS   10'h210
`define IDX_EVT_MASK     10'h211

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BIT_RX_SUMMARY   0
`define BIT_TX_SUMMARY   1
`define BIT_PORT_EN      0
`define BIT_PIN_EN       3
`define BIT_EVT_TX       0
`define BIT_EVT_RX       1

// ----------------------------------------------------------------------
// reset values and valid-bit masks
// ----------------------------------------------------------------------
`define RST_MASK         8'h00
`define RST_TX_EN        8'hfc
`define RST_RX_EN        8'hef
`define RST_CTRL         8'h00
`define TX_PEND_BITS     8'hf8
`define RX_PEND_BITS     8'hef
`define RX_DUAL_EDGE     8'h80

// ----------------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------------
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

// ### design/cell_irq_pkg.sv
/*
  Types shared by the cell interrupt block. Assumes the constants of
  cell_irq_defs.svh for all numbers.
*/
package cell_irq_pkg;

  // four header octets of a received cell, octet 1 first
  typedef struct packed {
    logic [7:0] octet1;
    logic [7:0] octet2;
    logic [7:0] octet3;
    logic [7:0] octet4;
  } cell_hdr_t;

  // transmit side status levels, in indication bit order 7 down to 3
  typedef struct packed {
    logic parity_err;
    logic cell_start_err;
    logic tx_overflow;
    logic rx_overflow;
    logic cell_sent;
  } tx_status_t;

endpackage

// ### design/edge_latch.sv
/*
  Per-bit edge catcher with sticky pending bits, cleared by a one-cycle
  clear pulse. Assumes status levels come from logic on the same clock.
*/
`timescale 1ns/10ps
module edge_latch #(
  parameter int         WIDTH = 8,
  parameter [WIDTH-1:0] DUAL  = '0
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // status levels, enables and read clear
  input  wire logic [WIDTH-1:0] status,
  input  wire logic [WIDTH-1:0] enable,
  input  wire logic             clear,
  // sticky pending bits and new-set pulse
  output logic      [WIDTH-1:0] pend,
  output logic                  any_set
);

  logic [WIDTH-1:0] prev_q;
  logic [WIDTH-1:0] set;

  // one cell per bit: dual bits fire on any change, others on 0 to 1
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      assign set[i] = enable[i] &
                      (DUAL[i] ? (status[i] ^ prev_q[i])
                               : (status[i] & ~prev_q[i]));
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          pend[i] <= 1'b0;
        else
          pend[i] <= (pend[i] & ~clear) | set[i];
      end
    end
  endgenerate

  // previous status for edge detection
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      prev_q <= '0;
    else
      prev_q <= status;
  end

  assign any_set = |set;

endmodule // edge_latch

// ### dv/cell_irq_sva.sv
/*
  Port-level checks of the cell interrupt block.
  Assumes one clock domain and a bind into the block's top module.
*/
`timescale 1ns/10ps
module cell_irq_sva
  import cell_irq_pkg::*;
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus handshakes
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  // cell side
  input wire tx_status_t  tx_status,
  input wire logic [7:0]  rx_status,
  input wire logic        hdr_valid,
  input wire cell_hdr_t   rx_hdr,
  input wire cell_hdr_t   idle_hdr,
  input wire logic [7:0]  idle_mask_byte1,
  input wire logic        idle_match,
  input wire logic        host_irq_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------------------------
  // helper: cycles since an event that may pull the pin low
  // ----------------------------------------------------------------
  tx_status_t tx_prev_q;
  logic [7:0] rx_prev_q;
  logic [2:0] quiet_q;

  // saturating count; writes count as events since enables gate the pin
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_prev_q <= '0;
      rx_prev_q <= 8'h00;
      quiet_q   <= 3'h7;
    end
    else
    begin
      tx_prev_q <= tx_status;
      rx_prev_q <= rx_status;
      if (tx_status != tx_prev_q || rx_status != rx_prev_q || bvalid)
        quiet_q <= 3'h0;
      else if (quiet_q != 3'h7)
        quiet_q <= quiet_q + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence b_late;
    !bvalid ##1 bvalid;
  endsequence

  wr_answer_a: assert property (wr_take |=> b_late)
    else $error("write response not two edges after handshake");
  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before bready");
  aw_block_a: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while response pending");
  rd_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read data not one cycle after address");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data changed before rready");
  ar_block_a: assert property (rvalid |-> !arready)
    else $error("read accepted while data pending");
  idle_hit_a: assert property (hdr_valid && rx_hdr == idle_hdr |=> idle_match)
    else $error("equal header not flagged idle");
  idle_miss_a: assert property (hdr_valid && ((rx_hdr.octet1 ^ idle_hdr.octet1)
    & ~idle_mask_byte1) != 8'h00 |=> !idle_match)
    else $error("unmasked octet one difference flagged idle");
  pin_cause_a: assert property ($fell(host_irq_n) |-> quiet_q < 3'h3)
    else $error("pin asserted without a recent cause");
endmodule // cell_irq_sva

bind cell_interrupt_enable_status cell_irq_sva cell_irq_sva_inst (.*);

// ### dv/host_model.sv
/*
  Host processor model: AXI4-Lite master tasks for register access.
  Assumes one clock; a wait that runs out raises hang.
*/
`timescale 1ns/10ps
`include "cell_irq_defs.svh"
module host_model (
  // clock
  input  wire logic        aclk,
  // write side
  output logic             awvalid,
  input  wire logic        awready,
  output logic      [11:0] awaddr,
  output logic             wvalid,
  input  wire logic        wready,
  output logic      [31:0] wdata,
  output logic      [3:0]  wstrb,
  input  wire logic        bvalid,
  output logic             bready,
  input  wire logic [1:0]  bresp,
  // read side
  output logic             arvalid,
  input  wire logic        arready,
  output logic      [11:0] araddr,
  input  wire logic        rvalid,
  output logic             rready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  // bench status
  output logic             hang
);
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  // idle bus from time zero
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, hang} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
  end

  // one write; address and data offered together, each dropped when taken
  task automatic wr(input logic [9:0] idx, input logic [7:0] d,
                    output logic [1:0] resp);
    int n;
    if (idx == `IDX_TX_EN)
      d[1:0] = 2'b00;
    if (idx == `IDX_RX_EN)
      d[4] = 1'b0;
    resp = 2'bxx;
    @(posedge aclk);
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h0, d};
    wstrb   <= 4'h1;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge aclk);
      if (bvalid)
      begin
        resp = bresp;
        break;
      end
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (n == 64)
      hang <= 1'b1;
  endtask

  // one read; rready held until the data is seen
  task automatic rd(input logic [9:0] idx, output logic [31:0] d,
                    output logic [1:0] resp);
    int n;
    d = 'x;
    resp = 2'bxx;
    @(posedge aclk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge aclk);
      if (rvalid)
      begin
        d = rdata;
        resp = rresp;
        break;
      end
      if (arready)
        arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (n == 64)
      hang <= 1'b1;
  endtask
endmodule // host_model

// ### dv/testbench.sv
/*
  Self-checking bench: registers, idle screening, indications, pin.
  Assumes the host model drives the bus and the checker is bound.
*/
`timescale 1ns/10ps
`include "cell_irq_defs.svh"
module testbench
  import cell_irq_pkg::*;
  ;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, hang;
  logic        hdr_valid, idle_match, host_irq_n, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [7:0]  rx_status, idle_mask_byte1;
  tx_status_t  tx_status;
  cell_hdr_t   rx_hdr, idle_hdr;
  int          n_mismatch, checks_done, k;

  // every port meets the bench signal of the same name
  cell_interrupt_enable_status cell_interrupt_enable_status_inst (.*);
  host_model host_model_inst (.*);

  // ----------------------------------------------------------------
  // clock, helpers and verdict
  // ----------------------------------------------------------------
  // 100 MHz
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wchk(input logic [9:0] idx, input logic [7:0] d,
                      input logic [1:0] er = `RESP_OKAY);
    logic [1:0] r;
    host_model_inst.wr(idx, d, r);
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic rchk(input logic [9:0] idx, input logic [7:0] e,
                      input logic [1:0] er = `RESP_OKAY);
    logic [31:0] d;
    logic [1:0]  r;
    host_model_inst.rd(idx, d, r);
    chk(d, {24'h0, e});
    chk({30'h0, r}, {30'h0, er});
  endtask
  // sample away from the edge so registered outputs have settled
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic pin(input logic e);
    chk({31'h0, host_irq_n}, {31'h0, e});
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // a bus wait that ran out ends the run as a mismatch
  always @(posedge aclk)
  begin
    if (hang === 1'b1)
    begin
      n_mismatch++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    {aresetn, hdr_valid, n_mismatch, checks_done} = '0;
    tx_status = '0;
    rx_status = 8'h00;
    idle_hdr = 32'h0000_0001;
    rx_hdr = 32'h0000_0000;
    idle_mask_byte1 = 8'h80; // octet one bit 7 is not compared until the exact-match test
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    pin(1'b1);
    for (k = 0; k < 3; k++)
      rchk(`IDX_MASK2 + k, 8'h00);
    rchk(`IDX_TX_EN, 8'hfc);
    rchk(`IDX_RX_EN, 8'hef);
    rchk(`IDX_TX_PEND, 8'h00);
    for (k = 0; k < 3; k++)
    begin
      wchk(`IDX_MASK2 + k, 8'h5a ^ 8'(k));
      rchk(`IDX_MASK2 + k, 8'h5a ^ 8'(k));
    end
    wchk(10'h0ff, 8'h01, `RESP_SLVERR);
    rchk(10'h0ff, 8'h00, `RESP_SLVERR);
    $display("test registers done");

    // one masked bit per octet, octet one differs in its masked bit too
    for (k = 0; k < 3; k++)
    begin
      @(posedge aclk);
      rx_hdr <= 32'h8000_0001 ^ (32'h20 << (16 - 8 * k));
      wchk(`IDX_MASK2 + k, 8'h20);
      @(posedge aclk);
      hdr_valid <= 1'b1;
      @(posedge aclk);
      hdr_valid <= 1'b0;
      @(negedge aclk);
      chk({31'h0, idle_match}, 32'h1);
      wchk(`IDX_MASK2 + k, 8'h00);
      @(posedge aclk);
      hdr_valid <= 1'b1;
      @(posedge aclk);
      hdr_valid <= 1'b0;
      @(negedge aclk);
      chk({31'h0, idle_match}, 32'h0);
    end
    // exact header matches; an unmasked octet one bit then breaks it
    @(posedge aclk);
    {hdr_valid, rx_hdr, idle_mask_byte1} <= {1'b1, 32'h0000_0001, 8'h00};
    @(posedge aclk);
    rx_hdr <= 32'h8000_0001;
    @(negedge aclk);
    chk({31'h0, idle_match}, 32'h1);
    @(posedge aclk);
    hdr_valid <= 1'b0;
    @(negedge aclk);
    chk({31'h0, idle_match}, 32'h0);
    $display("test idle screening done");

    wchk(`IDX_SUMMARY_EN, 8'h02);
    wchk(`IDX_PORT_EN, 8'h01);
    wchk(`IDX_MODE, 8'h08);
    @(posedge aclk);
    tx_status <= 5'b00001;
    settle(3);
    pin(1'b0);
    wchk(`IDX_MODE, 8'h00);
    settle(2);
    pin(1'b1);
    wchk(`IDX_MODE, 8'h08);
    settle(2);
    pin(1'b0);
    rchk(`IDX_TX_PEND, 8'h08);
    settle(2);
    pin(1'b1);
    @(posedge aclk);
    tx_status <= 5'b00000;
    settle(2);
    rchk(`IDX_TX_PEND, 8'h00);
    wchk(`IDX_TX_EN, 8'h00);
    @(posedge aclk);
    tx_status <= 5'b10000;
    settle(2);
    rchk(`IDX_TX_PEND, 8'h00);
    @(posedge aclk);
    tx_status <= 5'b00000;
    wchk(`IDX_TX_EN, 8'hf8);
    @(posedge aclk);
    tx_status <= 5'b11111;
    settle(2);
    rchk(`IDX_TX_PEND, 8'hf8);
    $display("test transmit indications done");

    wchk(`IDX_SUMMARY_EN, 8'h01);
    wchk(`IDX_RX_EN, 8'hef);
    @(posedge aclk);
    rx_status <= 8'h80;
    settle(3);
    pin(1'b0);
    rchk(`IDX_RX_PEND, 8'h80);
    @(posedge aclk);
    rx_status <= 8'h00;
    settle(2);
    rchk(`IDX_RX_PEND, 8'h80);
    @(posedge aclk);
    rx_status <= 8'h11;
    settle(2);
    rchk(`IDX_RX_PEND, 8'h01);
    @(posedge aclk);
    rx_status <= 8'h00;
    settle(2);
    rchk(`IDX_RX_PEND, 8'h00);
    $display("test receive indications done");

    @(posedge aclk);
    tx_status <= 5'b00000;
    wchk(`IDX_EVT_STATUS, 8'h03);
    rchk(`IDX_EVT_STATUS, 8'h00);
    @(posedge aclk);
    tx_status <= 5'b00001;
    settle(2);
    rchk(`IDX_EVT_STATUS, 8'h01);
    chk({31'h0, irq}, 32'h0);
    wchk(`IDX_EVT_MASK, 8'h01);
    settle(2);
    chk({31'h0, irq}, 32'h1);
    wchk(`IDX_EVT_STATUS, 8'h01);
    settle(2);
    chk({31'h0, irq}, 32'h0);
    $display("test event interrupt done");
    close_out();
  end
endmodule // testbench
